/* rtl/async_phase_pwm_timer.sv */
// Overview of operation
// - mode one counts up then down repeatedly
// - action two non-inverted, three inverted PWM
// - up match clears, down match sets output
// - eight-bit resolution, turnaround fixed at MAX
// - count holds MAX one timer cycle
// - overflow flag set on reaching BOTTOM
// - period is 510 prescaled timer cycles
// - compare BOTTOM low, MAX high output
// - leaving MAX drives up-match level at MAX
// - start above compare skips the up match
// - async writes land after two crystal edges
// - each async register has own holding register
// - compare suppressed while count/compare write pending
// - wake logic rearms after one crystal cycle
// - wake starts on next timer clock cycle
// - count read via register updated per crystal edge
// - async flags take three cycles plus one timer
// - output pin changes on timer clock only
// - async select picks crystal, frees port pins
// - prescaler divides, clear bit resets it
// - clock select codes stop, 1, 8..1024
// - action zero port, top compare handled at TOP
// - busy set on async write, cleared on transfer
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module async_phase_pwm_timer
    import async_pwm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // crystal pins
    input wire logic crystalInputPin,
    output logic crystalPinsReleased,
    // compare output pin
    output logic compareOutputPin,
    output logic compareOutputEnable,
    // sleep handshake
    input wire logic powerSaveSleep,
    output logic wakeRequest,
    output logic irqRequest
);
    import async_pwm_pkg::*;

    function automatic logic [PRESCALE_BITS-1:0] divMask(input logic [2:0] cs);
        case (cs)
            3'h2: divMask = 10'h007;
            3'h3: divMask = 10'h01F;
            3'h4: divMask = 10'h03F;
            3'h5: divMask = 10'h07F;
            3'h6: divMask = 10'h0FF;
            3'h7: divMask = 10'h3FF;
            default: divMask = 10'h000;
        endcase
    endfunction

    function automatic ctrl_t decodeCtrl(input logic [7:0] b);
        decodeCtrl.wgm = {b[CTRL_WGM1_BIT], b[CTRL_WGM0_BIT]};
        decodeCtrl.com = b[CTRL_COM_HI:CTRL_COM_LO];
        decodeCtrl.cs = b[CTRL_CS_HI:CTRL_CS_LO];
    endfunction

    logic [7:0] controlByte;
    logic [7:0] countValue;
    logic [7:0] compareValue;
    logic [7:0] compareActive;
    logic [7:0] countRead;
    logic asyncSel;
    logic [1:0] irqEnable;
    logic [1:0] flags;
    logic [2:0] holdBusy;
    logic [7:0] holdData [3];
    logic [1:0] holdEdges [3];
    logic [2:0] holdLoad;
    logic [2:0] xtalSync;
    logic xtalRise;
    logic srcTick;
    logic timerTick;
    logic [PRESCALE_BITS-1:0] prescaler;
    logic prescalerClear;
    logic countingDown;
    logic countWriteBlock;
    logic ocLevel;
    logic wakeArmed;
    logic [FLAG_SYNC_CYCLES-1:0] ovfPipe;
    logic [FLAG_SYNC_CYCLES-1:0] cmpPipe;
    logic ovfEvent;
    logic cmpEvent;
    logic ovfSet;
    logic cmpSet;
    logic [7:0] awaddrHeld;
    logic [31:0] wdataHeld;
    logic awHeld;
    logic wHeld;
    logic writeFire;
    logic [7:0] writeByte;
    ctrl_t ctrl;
    logic pwmMode;
    logic compareBlocked;
    logic matchNow;
    logic [7:0] next_count;

    assign ctrl = decodeCtrl(controlByte);
    assign pwmMode = (ctrl.wgm == WGM_PHASE_CORRECT);

    // crystal pin synchroniser and rising edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            xtalSync <= 3'h0;
        else
            xtalSync <= {xtalSync[1:0], crystalInputPin};
    end
    assign xtalRise = xtalSync[1] & ~xtalSync[2];

    // source clock and prescaler
    assign srcTick = asyncSel ? xtalRise : 1'b1;
    assign crystalPinsReleased = asyncSel;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prescaler <= 10'h000;
        else if (prescalerClear)
            prescaler <= 10'h000;
        else if (srcTick)
            prescaler <= prescaler + 10'h001;
    end

    always_comb
    begin
        if (ctrl.cs == 3'h0)
            timerTick = 1'b0;
        else
            timerTick = srcTick && ((prescaler & divMask(ctrl.cs)) == divMask(ctrl.cs));
    end

    // axi write channel
    assign awready = ~awHeld;
    assign wready = ~wHeld;
    assign writeFire = awHeld && wHeld && !bvalid;
    assign writeByte = wdataHeld[7:0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awaddrHeld <= 8'h00;
            wdataHeld <= 32'h00000000;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld <= 1'b1;
                awaddrHeld <= awaddr;
            end
            else if (writeFire)
                awHeld <= 1'b0;
            if (wvalid && wready)
            begin
                wHeld <= 1'b1;
                wdataHeld <= wstrb[0] ? wdata : 32'h00000000;
            end
            else if (writeFire)
                wHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (writeFire)
        begin
            bvalid <= 1'b1;
            case (awaddrHeld)
                OFS_CONTROL, OFS_COUNT, OFS_COMPARE, OFS_ASYNC_STATUS,
                OFS_FLAGS, OFS_IRQ_ENABLE, OFS_SPECIAL: bresp <= RESP_OKAY;
                default: bresp <= RESP_SLVERR;
            endcase
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // plain software registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            asyncSel <= 1'b0;
            irqEnable <= ENABLE_RESET;
            prescalerClear <= 1'b0;
        end
        else
        begin
            prescalerClear <= writeFire && awaddrHeld == OFS_SPECIAL && writeByte[SPECIAL_PRESCALER_CLEAR_BIT];
            if (writeFire && awaddrHeld == OFS_ASYNC_STATUS)
                asyncSel <= writeByte[STAT_ASYNC_BIT];
            if (writeFire && awaddrHeld == OFS_IRQ_ENABLE)
                irqEnable <= writeByte[1:0];
        end
    end

    // holding registers, one per async destination
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_hold
            logic hit;
            assign hit = writeFire && asyncSel && (awaddrHeld == (i == 0 ? OFS_COUNT : i == 1 ? OFS_COMPARE : OFS_CONTROL));
            assign holdLoad[i] = holdBusy[i] && xtalRise && (holdEdges[i] == XFER_EDGES - 2'h1);
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    holdBusy[i] <= 1'b0;
                    holdData[i] <= 8'h00;
                    holdEdges[i] <= 2'h0;
                end
                else if (hit)
                begin
                    holdBusy[i] <= 1'b1;
                    holdData[i] <= writeByte;
                    holdEdges[i] <= 2'h0;
                end
                else if (holdLoad[i])
                    holdBusy[i] <= 1'b0;
                else if (holdBusy[i] && xtalRise)
                    holdEdges[i] <= holdEdges[i] + 2'h1;
            end
        end
    endgenerate

    // control and compare destinations
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            controlByte <= CONTROL_RESET;
            compareValue <= COMPARE_RESET;
        end
        else
        begin
            if (holdLoad[SLOT_CONTROL])
                controlByte <= holdData[SLOT_CONTROL] & CTRL_WRITE_MASK;
            else if (writeFire && !asyncSel && awaddrHeld == OFS_CONTROL)
                controlByte <= writeByte & CTRL_WRITE_MASK;
            if (holdLoad[SLOT_COMPARE])
                compareValue <= holdData[SLOT_COMPARE];
            else if (writeFire && !asyncSel && awaddrHeld == OFS_COMPARE)
                compareValue <= writeByte;
        end
    end

    // counter, dual slope
    assign compareBlocked = holdBusy[SLOT_COUNT] | holdBusy[SLOT_COMPARE] | countWriteBlock;
    assign matchNow = (countValue == compareActive) && !compareBlocked;

    always_comb
    begin
        next_count = countValue;
        if (!pwmMode)
            next_count = countValue + 8'h01;
        else if (!countingDown && countValue == COUNT_MAX)
            next_count = COUNT_MAX - 8'h01;
        else if (countingDown && countValue == COUNT_BOTTOM)
            next_count = COUNT_BOTTOM + 8'h01;
        else if (countingDown)
            next_count = countValue - 8'h01;
        else
            next_count = countValue + 8'h01;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            countValue <= COUNT_RESET;
            countingDown <= 1'b0;
            countWriteBlock <= 1'b0;
        end
        else if (holdLoad[SLOT_COUNT] || (writeFire && !asyncSel && awaddrHeld == OFS_COUNT))
        begin
            countValue <= holdLoad[SLOT_COUNT] ? holdData[SLOT_COUNT] : writeByte;
            countWriteBlock <= 1'b1;
        end
        else if (timerTick)
        begin
            countValue <= next_count;
            countWriteBlock <= 1'b0;
            if (pwmMode && countValue == COUNT_MAX)
                countingDown <= 1'b1;
            else if (countValue == COUNT_BOTTOM)
                countingDown <= 1'b0;
        end
    end

    // compare buffer updates at TOP
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            compareActive <= COMPARE_RESET;
        else if (!pwmMode || (timerTick && countValue == COUNT_MAX))
            compareActive <= compareValue;
    end

    // waveform output on timer ticks only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ocLevel <= 1'b0;
        else if (timerTick && pwmMode && ctrl.com[1])
        begin
            if (countValue == COUNT_MAX)
            begin
                if (compareValue == COUNT_MAX && compareActive == COUNT_MAX)
                    ocLevel <= (ctrl.com == COM_NON_INVERTED);
                else if (compareActive == COUNT_MAX || matchNow)
                    ocLevel <= (ctrl.com == COM_INVERTED);
            end
            else if (matchNow && (!countingDown || countValue == COUNT_BOTTOM))
                ocLevel <= (ctrl.com == COM_INVERTED);
            else if (matchNow)
                ocLevel <= (ctrl.com == COM_NON_INVERTED);
        end
    end
    assign compareOutputPin = ocLevel;
    assign compareOutputEnable = pwmMode ? ctrl.com[1] : (ctrl.com != COM_DISCONNECTED);

    // timer events and flag crossing
    assign ovfEvent = timerTick && (pwmMode ? (countingDown && countValue == COUNT_BOTTOM + 8'h01)
                                            : (countValue == COUNT_MAX));
    assign cmpEvent = timerTick && matchNow;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ovfPipe <= 3'h0;
            cmpPipe <= 3'h0;
        end
        else
        begin
            ovfPipe <= {ovfPipe[FLAG_SYNC_CYCLES-2:0], ovfEvent};
            cmpPipe <= {cmpPipe[FLAG_SYNC_CYCLES-2:0], cmpEvent};
        end
    end
    assign ovfSet = asyncSel ? ovfPipe[FLAG_SYNC_CYCLES-1] : ovfEvent;
    assign cmpSet = asyncSel ? cmpPipe[FLAG_SYNC_CYCLES-1] : cmpEvent;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags <= 2'h0;
        else
        begin
            if (ovfSet)
                flags[FLAG_OVERFLOW_BIT] <= 1'b1;
            else if (writeFire && awaddrHeld == OFS_FLAGS && writeByte[FLAG_OVERFLOW_BIT])
                flags[FLAG_OVERFLOW_BIT] <= 1'b0;
            if (cmpSet)
                flags[FLAG_COMPARE_BIT] <= 1'b1;
            else if (writeFire && awaddrHeld == OFS_FLAGS && writeByte[FLAG_COMPARE_BIT])
                flags[FLAG_COMPARE_BIT] <= 1'b0;
        end
    end
    assign irqRequest = |(flags & irqEnable);

    // wake from power-save
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wakeRequest <= 1'b0;
            wakeArmed <= 1'b1;
        end
        else if (!powerSaveSleep)
        begin
            wakeRequest <= 1'b0;
            if (srcTick && !wakeRequest)
                wakeArmed <= 1'b1;
        end
        else if (timerTick && wakeArmed && irqRequest)
        begin
            wakeRequest <= 1'b1;
            wakeArmed <= 1'b0;
        end
    end

    // count readback register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            countRead <= COUNT_RESET;
        else if (!asyncSel || xtalRise)
            countRead <= countValue;
    end

    // axi read channel
    assign arready = ~rvalid;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (araddr)
                OFS_CONTROL: rdata <= {24'h000000, controlByte};
                OFS_COUNT: rdata <= {24'h000000, countRead};
                OFS_COMPARE: rdata <= {24'h000000, compareValue};
                OFS_ASYNC_STATUS: rdata <= {28'h0000000, asyncSel, holdBusy[SLOT_COUNT],
                                            holdBusy[SLOT_COMPARE], holdBusy[SLOT_CONTROL]};
                OFS_FLAGS: rdata <= {30'h00000000, flags};
                OFS_IRQ_ENABLE: rdata <= {30'h00000000, irqEnable};
                OFS_SPECIAL: rdata <= 32'h00000000;
                default:
                begin
                    rdata <= 32'h00000000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
            rvalid <= 1'b0;
    end
endmodule
`default_nettype wire

/* pkg/async_pwm_pkg.sv */
`default_nettype none
package async_pwm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_ASYNC_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFS_SPECIAL = 8'h18;
    // timer_control_byte field positions
    localparam int CTRL_WGM0_BIT = 6;
    localparam int CTRL_COM_HI = 5;
    localparam int CTRL_COM_LO = 4;
    localparam int CTRL_WGM1_BIT = 3;
    localparam int CTRL_CS_HI = 2;
    localparam int CTRL_CS_LO = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;
    // async_status_byte field positions
    localparam int STAT_ASYNC_BIT = 3;
    localparam int STAT_COUNT_BUSY_BIT = 2;
    localparam int STAT_COMPARE_BUSY_BIT = 1;
    localparam int STAT_CONTROL_BUSY_BIT = 0;
    // flag and enable positions
    localparam int FLAG_COMPARE_BIT = 1;
    localparam int FLAG_OVERFLOW_BIT = 0;
    localparam int SPECIAL_PRESCALER_CLEAR_BIT = 0;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    // counter limits and encodings
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] WGM_PHASE_CORRECT = 2'h1;
    localparam logic [1:0] COM_DISCONNECTED = 2'h0;
    localparam logic [1:0] COM_NON_INVERTED = 2'h2;
    localparam logic [1:0] COM_INVERTED = 2'h3;
    // crossing counts
    localparam logic [1:0] XFER_EDGES = 2'h2;
    localparam int FLAG_SYNC_CYCLES = 3;
    localparam int PRESCALE_BITS = 10;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // holding register slots
    typedef enum logic [1:0] {
        SLOT_COUNT = 2'b00,
        SLOT_COMPARE = 2'b01,
        SLOT_CONTROL = 2'b10
    } slot_t;
    // decoded control byte
    typedef struct packed {
        logic [1:0] wgm;
        logic [1:0] com;
        logic [2:0] cs;
    } ctrl_t;
endpackage
`default_nettype wire

/* bench/async_pwm_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module async_pwm_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // pins
    input wire logic crystalInputPin,
    input wire logic crystalPinsReleased,
    input wire logic compareOutputPin,
    input wire logic compareOutputEnable,
    input wire logic powerSaveSleep,
    input wire logic wakeRequest,
    input wire logic irqRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer not held");
    chk_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer not held");
    chk_write_cause: assert property ($rose(bvalid) |-> !$past(awready) && !$past(wready))
        else $error("write answer without address and data");
    chk_ar_refuse: assert property (rvalid |-> !arready)
        else $error("read address taken while answer pending");
    chk_byte_width: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_wake_cause: assert property ($rose(wakeRequest) |-> $past(powerSaveSleep) && $past(irqRequest))
        else $error("wake without sleep and pending interrupt");
    chk_wake_level: assert property (wakeRequest && powerSaveSleep |=> wakeRequest)
        else $error("wake dropped during sleep");

    cover property (bvalid && bready);
    cover property (rvalid && rready && rresp == 2'h2);
    cover property ($rose(wakeRequest));
    cover property ($fell(compareOutputPin));
endmodule

bind async_phase_pwm_timer async_pwm_properties u_async_pwm_properties (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .crystalInputPin(crystalInputPin),
    .crystalPinsReleased(crystalPinsReleased), .compareOutputPin(compareOutputPin),
    .compareOutputEnable(compareOutputEnable), .powerSaveSleep(powerSaveSleep),
    .wakeRequest(wakeRequest), .irqRequest(irqRequest)
);
`default_nettype wire

/* bench/async_phase_pwm_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module async_phase_pwm_timer_tb;
    import async_pwm_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic crystalInputPin = 1'b0, powerSaveSleep = 1'b0;
    logic crystalPinsReleased, compareOutputPin, compareOutputEnable, wakeRequest, irqRequest;
    int failures = 0, tests_run = 0, xtalCnt = 0;

    async_phase_pwm_timer u_async_phase_pwm_timer (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .crystalInputPin(crystalInputPin),
        .crystalPinsReleased(crystalPinsReleased), .compareOutputPin(compareOutputPin),
        .compareOutputEnable(compareOutputEnable), .powerSaveSleep(powerSaveSleep),
        .wakeRequest(wakeRequest), .irqRequest(irqRequest)
    );

    always #2 clk = ~clk;

    // free-running crystal, 40 system clocks a period
    always @(posedge clk)
    begin
        xtalCnt <= (xtalCnt == 19) ? 0 : xtalCnt + 1;
        if (xtalCnt == 19)
        begin
            crystalInputPin <= ~crystalInputPin;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, awT, wT, got;
        int n, stall;
        aw = 1'b1; w = 1'b1; got = 1'b0; n = 0; stall = $urandom % 3;
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b0;
        while (!got)
        begin
            @(negedge clk);
            awT = aw && awready; wT = w && wready; got = bready && bvalid; r = bresp;
            @(posedge clk);
            if (awT) begin awvalid <= 1'b0; aw = 1'b0; end
            if (wT) begin wvalid <= 1'b0; w = 1'b0; end
            if (!got && n >= stall) bready <= 1'b1;
            n++;
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, arT, got;
        int n, stall;
        ar = 1'b1; got = 1'b0; n = 0; stall = $urandom % 3;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b0;
        while (!got)
        begin
            @(negedge clk);
            arT = ar && arready; got = rready && rvalid; d = rdata; r = rresp;
            @(posedge clk);
            if (arT) begin arvalid <= 1'b0; ar = 1'b0; end
            if (!got && n >= stall) rready <= 1'b1;
            n++;
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic count_high(input int cycles, output int h);
        h = 0;
        repeat (cycles)
        begin
            @(negedge clk);
            if (compareOutputPin === 1'b1) h++;
        end
        @(posedge clk);
    endtask

    function automatic logic [7:0] ctrl_byte(input logic [1:0] com, input logic [2:0] cs);
        return {1'b0, 1'b1, com, 1'b0, cs};
    endfunction

    function automatic int exp_high(input logic [7:0] c, input logic [1:0] com, input int n);
        return (com == COM_INVERTED) ? n * (510 - 2 * int'(c)) : n * 2 * int'(c);
    endfunction

    initial
    begin
        #360000;
        failures++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] d, d2;
        logic [1:0] r, com;
        logic [7:0] c;
        logic [7:0] offs [7];
        int h, k;
        offs = '{OFS_CONTROL, OFS_COUNT, OFS_COMPARE, OFS_ASYNC_STATUS, OFS_FLAGS, OFS_IRQ_ENABLE, OFS_SPECIAL};
        void'($urandom(96));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values and unmapped place
        foreach (offs[i])
        begin
            axi_read(offs[i], d, r);
            check("reset value", d, 32'h00000000);
        end
        axi_read(8'h1C, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        check("unmapped data", d, 32'h00000000);
        axi_write(8'h1C, 32'h000000FF, r);
        check("unmapped wresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(OFS_CONTROL, 32'h000000FF, r);
        check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
        axi_read(OFS_CONTROL, d, r);
        check("control mask", d, {24'h0, CTRL_WRITE_MASK});
        // duty over one period, both polarities, extremes and random
        for (k = 0; k < 6; k++)
        begin
            c = (k % 3 == 0) ? COUNT_BOTTOM : (k % 3 == 1) ? COUNT_MAX : 8'($urandom_range(1, 254));
            com = (k < 3) ? COM_NON_INVERTED : COM_INVERTED;
            axi_write(OFS_COMPARE, {24'h0, c}, r);
            axi_write(OFS_CONTROL, {24'h0, ctrl_byte(com, 3'h1)}, r);
            repeat (1100) @(posedge clk);
            count_high(510, h);
            check("pwm high", h, exp_high(c, com, 1));
            check("pin enable", compareOutputEnable, 1'b1);
        end
        // divide by eight
        axi_write(OFS_SPECIAL, 32'h00000001, r);
        axi_read(OFS_SPECIAL, d, r);
        check("prescaler clear", d, 32'h00000000);
        axi_write(OFS_CONTROL, {24'h0, ctrl_byte(COM_NON_INVERTED, 3'h2)}, r);
        repeat (9000) @(posedge clk);
        count_high(4080, h);
        check("pwm high div8", h, exp_high(c, COM_INVERTED == com ? COM_NON_INVERTED : com, 8));
        axi_read(OFS_FLAGS, d, r);
        check("overflow flag", d[FLAG_OVERFLOW_BIT], 1'b1);
        // stopped timer, flag clear, interrupt request
        axi_write(OFS_CONTROL, {24'h0, ctrl_byte(COM_NON_INVERTED, 3'h0)}, r);
        axi_read(OFS_COUNT, d, r);
        repeat (50) @(posedge clk);
        axi_read(OFS_COUNT, d2, r);
        check("stopped count", d2, d);
        axi_write(OFS_FLAGS, 32'h00000003, r);
        axi_write(OFS_IRQ_ENABLE, 32'h00000001, r);
        check("irq idle", irqRequest, 1'b0);
        axi_write(OFS_CONTROL, {24'h0, ctrl_byte(COM_NON_INVERTED, 3'h1)}, r);
        repeat (600) @(posedge clk);
        check("irq overflow", irqRequest, 1'b1);
        // clock source switch into crystal domain
        axi_write(OFS_IRQ_ENABLE, 32'h00000000, r);
        axi_write(OFS_ASYNC_STATUS, 32'h00000008, r);
        check("pins released", crystalPinsReleased, 1'b1);
        c = 8'($urandom_range(1, 254));
        axi_write(OFS_CONTROL, 32'h00000041, r);
        axi_write(OFS_COUNT, {24'h0, 8'($urandom)}, r);
        axi_write(OFS_COMPARE, {24'h0, c}, r);
        axi_read(OFS_ASYNC_STATUS, d, r);
        check("all busy", d, 32'h0000000F);
        for (k = 0; k < 100 && d !== 32'h00000008; k++)
        begin
            axi_read(OFS_ASYNC_STATUS, d, r);
        end
        check("busy cleared", d, 32'h00000008);
        axi_read(OFS_COMPARE, d, r);
        check("async compare", d, {24'h0, c});
        axi_read(OFS_CONTROL, d, r);
        check("async control", d, 32'h00000041);
        axi_write(OFS_FLAGS, 32'h00000003, r);
        axi_write(OFS_IRQ_ENABLE, 32'h00000001, r);
        // sleep until the overflow wakes the core
        powerSaveSleep <= 1'b1;
        for (k = 0; k < 30000 && wakeRequest !== 1'b1; k++)
        begin
            @(negedge clk);
        end
        @(posedge clk);
        check("wake", wakeRequest, 1'b1);
        powerSaveSleep <= 1'b0;
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule
`default_nettype wire
